// ---- verilog/transceiver_control_status.sv ----
// transmit-off, laser fault, loss-of-signal, rate selects and two-wire status byte
`timescale 1ns/1ps
`include "xcvr_cfg.svh"

module transceiver_control_status (
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_B_IN,
  input  wire logic TX_OFF_IN,
  input  wire logic LASER_FAULT_IN,
  input  wire logic OUTPUT_UNSAFE_IN,
  input  wire logic RX_SIGNAL_LOST_IN,
  input  wire logic TX_RATE_SEL_IN,
  input  wire logic RX_RATE_SEL_IN,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output wire logic SDA_OUT,
  output wire logic SDA_OE_OUT,
  output wire logic LASER_EN_OUT,
  output wire logic TX_FAULT_OUT,
  output wire logic TX_PATH_RESET_OUT,
  output wire logic RX_SIGNAL_LOST_OUT,
  output wire logic TX_CLOCK_RECOVERY_EN_OUT,
  output wire logic RX_CLOCK_RECOVERY_EN_OUT
);

  xcvr_pkg::ctl_state_t q;
  xcvr_pkg::ctl_state_t d;
  xcvr_pkg::pins_t      pins;
  logic [7:0]           sync_out;
  logic [7:0]           status_byte;
  logic [7:0]           rd_byte;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_seen;
  logic                 stop_seen;
  logic                 off_fall;
  logic                 fault_cause;
  logic                 at_status;

  pin_sync u_pin_sync (
    .clk_in    (CLK_SYS_IN),
    .rst_b_in  (RST_B_IN),
    .raw_in    ({TX_OFF_IN, LASER_FAULT_IN, OUTPUT_UNSAFE_IN, RX_SIGNAL_LOST_IN,
                 TX_RATE_SEL_IN, RX_RATE_SEL_IN, SCL_IN, SDA_IN}),
    .clean_out (sync_out)
  );

  assign pins        = xcvr_pkg::pins_t'(sync_out);
  assign scl_rise    = pins.scl & ~q.scl_prev;
  assign scl_fall    = ~pins.scl & q.scl_prev;
  assign start_seen  = pins.scl & q.scl_prev & q.sda_prev & ~pins.sda;
  assign stop_seen   = pins.scl & q.scl_prev & ~q.sda_prev & pins.sda;
  assign off_fall    = q.off_prev & ~pins.tx_off;
  assign fault_cause = pins.laser_fault | pins.unsafe;
  assign at_status   = q.diag & (q.ptr == `CTRL_STATUS_OFFSET);

  // live view of pins and latches, so a read always shows current state
  always_comb
  begin
    status_byte                     = `EMPTY_BYTE;
    status_byte[`ST_OFF_STATE_BIT]  = pins.tx_off;
    status_byte[`ST_SW_OFF_BIT]     = q.sw_off;
    status_byte[`ST_FAULT_BIT]      = q.fault;
    status_byte[`ST_RX_LOST_BIT]    = pins.rx_lost;
  end

  // identification space and other diagnostic bytes hold no live state here
  assign rd_byte = at_status ? status_byte : `EMPTY_BYTE;

  always_comb
  begin
    d            = q;
    d.scl_prev   = pins.scl;
    d.sda_prev   = pins.sda;
    d.off_prev   = pins.tx_off;
    d.sda_out    = 1'b0;
    // set wins over the toggle clear, so a standing cause re-latches at once
    d.fault      = (q.fault & ~off_fall) | fault_cause;
    d.path_reset = off_fall & q.fault;
    d.laser_en   = ~(pins.tx_off | q.sw_off | d.fault);
    d.rx_lost    = pins.rx_lost;
    d.tx_cdr     = pins.tx_rate;
    d.rx_cdr     = pins.rx_rate;
    if (start_seen)
    begin
      d.phase  = xcvr_pkg::PH_DEV;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      d.phase  = xcvr_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (q.phase)
        xcvr_pkg::PH_DEV, xcvr_pkg::PH_ADDR, xcvr_pkg::PH_WR:
        begin
          d.sh  = {q.sh[6:0], pins.sda};
          d.cnt = q.cnt + 4'h1;
        end
        xcvr_pkg::PH_RD:     d.cnt = q.cnt + 4'h1;
        xcvr_pkg::PH_RD_ACK: d.master_ack = ~pins.sda;
        default:             d.cnt = q.cnt;
      endcase
    end
    else if (scl_fall)
    begin
      case (q.phase)
        xcvr_pkg::PH_DEV:
        begin
          if (q.cnt == `BYTE_BITS)
          begin
            if (q.sh[7:1] == `ID_DEV_ADDR || q.sh[7:1] == `DIAG_DEV_ADDR)
            begin
              d.diag   = q.sh[1];
              d.rw     = q.sh[0];
              d.sda_oe = 1'b1;
              d.phase  = xcvr_pkg::PH_DEV_ACK;
            end
            else
            begin
              d.phase = xcvr_pkg::PH_IDLE;
            end
          end
        end
        xcvr_pkg::PH_DEV_ACK:
        begin
          d.cnt = 4'h0;
          if (q.rw)
          begin
            d.sh     = rd_byte;
            d.sda_oe = ~rd_byte[7];
            d.phase  = xcvr_pkg::PH_RD;
          end
          else
          begin
            d.sda_oe = 1'b0;
            d.phase  = xcvr_pkg::PH_ADDR;
          end
        end
        xcvr_pkg::PH_ADDR:
        begin
          if (q.cnt == `BYTE_BITS)
          begin
            d.ptr    = q.sh;
            d.sda_oe = 1'b1;
            d.phase  = xcvr_pkg::PH_ADDR_ACK;
          end
        end
        xcvr_pkg::PH_ADDR_ACK, xcvr_pkg::PH_WR_ACK:
        begin
          d.sda_oe = 1'b0;
          d.cnt    = 4'h0;
          d.phase  = xcvr_pkg::PH_WR;
        end
        xcvr_pkg::PH_WR:
        begin
          if (q.cnt == `BYTE_BITS)
          begin
            // only bit 6 is writable; the mirrored bits ignore writes
            if (at_status)
            begin
              d.sw_off = q.sh[`ST_SW_OFF_BIT];
            end
            d.ptr    = q.ptr + 8'h01;
            d.sda_oe = 1'b1;
            d.phase  = xcvr_pkg::PH_WR_ACK;
          end
        end
        xcvr_pkg::PH_RD:
        begin
          if (q.cnt == `BYTE_BITS)
          begin
            d.sda_oe = 1'b0;
            d.ptr    = q.ptr + 8'h01;
            d.phase  = xcvr_pkg::PH_RD_ACK;
          end
          else
          begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
        xcvr_pkg::PH_RD_ACK:
        begin
          d.cnt = 4'h0;
          if (q.master_ack)
          begin
            d.sh     = rd_byte;
            d.sda_oe = ~rd_byte[7];
            d.phase  = xcvr_pkg::PH_RD;
          end
          else
          begin
            d.phase = xcvr_pkg::PH_IDLE;
          end
        end
        default: d.phase = xcvr_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      q          <= '0;
      q.phase    <= xcvr_pkg::PH_IDLE;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.off_prev <= 1'b1;
      q.sw_off   <= `SW_OFF_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign SDA_OUT                  = q.sda_out;
  assign SDA_OE_OUT               = q.sda_oe;
  assign LASER_EN_OUT             = q.laser_en;
  assign TX_FAULT_OUT             = q.fault;
  assign TX_PATH_RESET_OUT        = q.path_reset;
  assign RX_SIGNAL_LOST_OUT       = q.rx_lost;
  assign TX_CLOCK_RECOVERY_EN_OUT = q.tx_cdr;
  assign RX_CLOCK_RECOVERY_EN_OUT = q.rx_cdr;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);

  sequence s_fault_toggle;
    q.fault && q.off_prev && !pins.tx_off;
  endsequence
  sequence s_reset_pulse;
    TX_PATH_RESET_OUT ##1 !TX_PATH_RESET_OUT;
  endsequence
  sequence s_dev_match;
    q.phase == xcvr_pkg::PH_DEV && scl_fall && q.cnt == `BYTE_BITS
      && (q.sh[7:1] == `ID_DEV_ADDR || q.sh[7:1] == `DIAG_DEV_ADDR);
  endsequence

  property p_pin_off;
    pins.tx_off |=> !LASER_EN_OUT;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("laser on while pin off");

  property p_driven_low_first;
    $rose(LASER_EN_OUT) |-> $past(!pins.tx_off) && $past(!q.sw_off);
  endproperty
  a_driven_low_first: assert property (p_driven_low_first)
    else $error("laser enabled without transmit-off low");

  property p_sw_off;
    q.sw_off |=> !LASER_EN_OUT;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("laser on while software off");

  property p_toggle_reset;
    s_fault_toggle |=> s_reset_pulse;
  endproperty
  a_toggle_reset: assert property (p_toggle_reset)
    else $error("no single path reset on toggle");

  property p_fault_hold;
    TX_FAULT_OUT && !off_fall |=> TX_FAULT_OUT;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without toggle");

  property p_cause;
    fault_cause |=> TX_FAULT_OUT && !LASER_EN_OUT;
  endproperty
  a_cause: assert property (p_cause) else $error("fault cause not latched");

  property p_mirror;
    status_byte[`ST_FAULT_BIT] == TX_FAULT_OUT
      && RX_SIGNAL_LOST_OUT == $past(status_byte[`ST_RX_LOST_BIT]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("status byte out of step");

  property p_rates;
    TX_CLOCK_RECOVERY_EN_OUT == $past(pins.tx_rate)
      && RX_CLOCK_RECOVERY_EN_OUT == $past(pins.rx_rate);
  endproperty
  a_rates: assert property (p_rates) else $error("rate select not followed");

  property p_sw_write_only;
    $changed(q.sw_off) |-> $past(q.phase == xcvr_pkg::PH_WR && scl_fall && at_status);
  endproperty
  a_sw_write_only: assert property (p_sw_write_only)
    else $error("software off changed outside a write");

  property p_addr_ack;
    s_dev_match |=> SDA_OE_OUT && q.phase == xcvr_pkg::PH_DEV_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("device address not acked");

endmodule

// ---- verilog/xcvr_cfg.svh ----
// constants for the transceiver control and status block
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH

// two-wire device addresses, 7-bit form (0xA0 and 0xA2 as 8-bit write address)
`define ID_DEV_ADDR      7'h50
`define DIAG_DEV_ADDR    7'h51

// control and status byte in the diagnostic space
`define CTRL_STATUS_OFFSET 8'h6E
`define ST_OFF_STATE_BIT   7
`define ST_SW_OFF_BIT      6
`define ST_FAULT_BIT       2
`define ST_RX_LOST_BIT     1

// value read from any byte that holds no live state
`define EMPTY_BYTE       8'h00

// bits per two-wire byte
`define BYTE_BITS        4'h8

// pin synchroniser reset: transmit-off reads high, scl and sda idle high
`define PINS_RESET       8'h83
`define SW_OFF_RESET     1'b0

`endif

// ---- verilog/xcvr_pkg.sv ----
// types shared by the transceiver control and status block
package xcvr_pkg;

  // pins after synchronisation, msb first
  typedef struct packed {
    logic tx_off;
    logic laser_fault;
    logic unsafe;
    logic rx_lost;
    logic tx_rate;
    logic rx_rate;
    logic scl;
    logic sda;
  } pins_t;

  // two-wire slave phases, gray coded from PH_IDLE through the write byte loop and within the read byte loop
  typedef enum logic [3:0] {
    PH_IDLE     = 4'h0,
    PH_DEV      = 4'h1,
    PH_DEV_ACK  = 4'h3,
    PH_ADDR     = 4'h2,
    PH_ADDR_ACK = 4'h6,
    PH_WR       = 4'h7,
    PH_WR_ACK   = 4'h5,
    PH_RD       = 4'h4,
    PH_RD_ACK   = 4'hC
  } phase_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] clean;
  } sync_state_t;

  typedef struct packed {
    phase_t     phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       diag;
    logic       rw;
    logic       master_ack;
    logic       scl_prev;
    logic       sda_prev;
    logic       off_prev;
    logic       sw_off;
    logic       fault;
    logic       path_reset;
    logic       laser_en;
    logic       rx_lost;
    logic       tx_cdr;
    logic       rx_cdr;
    logic       sda_oe;
    logic       sda_out;
  } ctl_state_t;

endpackage

// ---- verilog/pin_sync.sv ----
// three-stage synchroniser with agreement filter for the module pins
`timescale 1ns/1ps
`include "xcvr_cfg.svh"

module pin_sync (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] raw_in,
  output wire logic [7:0] clean_out
);

  xcvr_pkg::sync_state_t q;
  xcvr_pkg::sync_state_t d;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      // s1 is only read by s2; the filter looks at s2 and s3
      always_comb
      begin
        d.s1[i]    = raw_in[i];
        d.s2[i]    = q.s1[i];
        d.s3[i]    = q.s2[i];
        d.clean[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.clean[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q.s1    <= `PINS_RESET;
      q.s2    <= `PINS_RESET;
      q.s3    <= `PINS_RESET;
      q.clean <= `PINS_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign clean_out = q.clean;

endmodule

// ---- verif/host_master.sv ----
// host board model: two-wire master with pulled-up data line
`timescale 1ns/1ps

module host_master (
  input  wire logic clk_in,
  input  wire logic dev_oe_in,
  output wire logic scl_out,
  output wire logic sda_out
);
  logic scl_q = 1'b1;
  logic low_q = 1'b0;

  // open drain with pull-up: high unless a party pulls low
  assign sda_out = ~(low_q | dev_oe_in);
  assign scl_out = scl_q;

  // 20 clocks a phase, four times the shortest the slave keeps up with
  task automatic half();
    repeat (20) @(posedge clk_in);
    #1;
  endtask

  // also serves as repeated start, clock low on entry
  task automatic start();
    low_q = 1'b0;
    half();
    scl_q = 1'b1;
    half();
    low_q = 1'b1;
    half();
    scl_q = 1'b0;
  endtask

  task automatic stop();
    low_q = 1'b1;
    half();
    scl_q = 1'b1;
    half();
    low_q = 1'b0;
    half();
  endtask

  // msb first, ack sampled at the end of the ninth high phase
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--)
    begin
      low_q = (i >= 0) ? ~b[i] : 1'b0;
      half();
      scl_q = 1'b1;
      half();
      ack = ~sda_out;
      scl_q = 1'b0;
    end
  endtask

  // single byte read ends with a nack so the slave lets go
  task automatic get(output logic [7:0] b);
    low_q = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      half();
      scl_q = 1'b1;
      half();
      if (i < 8)
        b = {b[6:0], sda_out};
      scl_q = 1'b0;
    end
  endtask
endmodule

// ---- verif/transceiver_control_status_tb_top.sv ----
// self-checking bench for the transceiver control and status block
`timescale 1ns/1ps
`include "xcvr_cfg.svh"

module transceiver_control_status_tb_top;
  localparam int LIMIT = 60000;
  logic       clk, rst_b, tx_off, fault_in, unsafe, lost, tx_rate, rx_rate;
  logic [7:0] d;
  logic       a;
  wire logic  scl, sda, sda_o, sda_oe, laser_en, tx_fault, prst, lost_o, tx_cr, rx_cr;
  int         n_mismatch, checked, cycles, n_prst, p;

  transceiver_control_status dut (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .TX_OFF_IN(tx_off), .LASER_FAULT_IN(fault_in),
    .OUTPUT_UNSAFE_IN(unsafe), .RX_SIGNAL_LOST_IN(lost), .TX_RATE_SEL_IN(tx_rate),
    .RX_RATE_SEL_IN(rx_rate), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .LASER_EN_OUT(laser_en), .TX_FAULT_OUT(tx_fault),
    .TX_PATH_RESET_OUT(prst), .RX_SIGNAL_LOST_OUT(lost_o),
    .TX_CLOCK_RECOVERY_EN_OUT(tx_cr), .RX_CLOCK_RECOVERY_EN_OUT(rx_cr));

  host_master host (.clk_in(clk), .dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (prst === 1'b1)
      n_prst++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pins need 4-5 edges through the synchroniser
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic outs(input string name, input logic [1:0] exp);
    check(name, {6'h00, laser_en, tx_fault}, {6'h00, exp});
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] v);
    logic a0, a1, a2;
    host.start();
    host.send(8'hA2, a0);
    host.send(off, a1);
    host.send(v, a2);
    host.stop();
    check("write ack", {5'h00, a0, a1, a2}, 8'h07);
  endtask

  task automatic rd(input logic [7:0] dev, input logic [7:0] off, output logic [7:0] v);
    logic a0, a1, a2;
    host.start();
    host.send(dev, a0);
    host.send(off, a1);
    host.start();
    host.send(dev | 8'h01, a2);
    host.get(v);
    host.stop();
    check("read ack", {5'h00, a0, a1, a2}, 8'h07);
  endtask

  task automatic status(input logic [7:0] exp);
    logic [7:0] v;
    rd(8'hA2, `CTRL_STATUS_OFFSET, v);
    check("status byte", v, exp);
  endtask

  // spacing far below the host's 10 ms: the device does not police it
  task automatic pulse_off();
    tx_off = 1'b1;
    settle();
    tx_off = 1'b0;
    settle();
  endtask

  initial
  begin
    {fault_in, unsafe, lost, tx_rate, rx_rate, rst_b} = 6'h00;
    tx_off = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    settle();
    outs("pulled-up off", 2'b00);
    status(8'h80);
    tx_off = 1'b0;
    settle();
    outs("laser on", 2'b10);
    for (int i = 0; i < 4; i++)
    begin
      {rx_rate, tx_rate} = i[1:0];
      settle();
      check("rate", {6'h00, rx_cr, tx_cr}, {6'h00, i[1:0]});
    end
    lost = 1'b1;
    settle();
    check("lost", {7'h00, lost_o}, 8'h01);
    status(8'h02);
    lost = 1'b0;
    settle();
    check("lost", {7'h00, lost_o}, 8'h00);
    $display("test pins done");
    wr(`CTRL_STATUS_OFFSET, 8'hFF);
    outs("soft off", 2'b00);
    status(8'h40);
    wr(`CTRL_STATUS_OFFSET, 8'hBF);
    outs("soft on", 2'b10);
    status(8'h00);
    $display("test soft off done");
    fault_in = 1'b1;
    settle();
    fault_in = 1'b0;
    settle();
    outs("fault latched", 2'b01);
    status(8'h04);
    p = n_prst;
    pulse_off();
    outs("fault cleared", 2'b10);
    check("path reset", 8'(n_prst - p), 8'h01);
    unsafe = 1'b1;
    settle();
    outs("unsafe", 2'b01);
    pulse_off();
    outs("cause held", 2'b01);
    unsafe = 1'b0;
    pulse_off();
    outs("unsafe gone", 2'b10);
    $display("test fault done");
    rd(8'hA0, 8'h6E, d);
    check("id byte", d, 8'h00);
    rd(8'hA2, 8'hFF, d);
    check("other byte", d, 8'h00);
    host.start();
    host.send(8'hA4, a);
    host.stop();
    check("foreign ack", {7'h00, a}, 8'h00);
    check("sda out level", {7'h00, sda_o}, 8'h00);
    $display("test address done");
    test_done();
  end
endmodule
